// ===== mt_map.svh
/*
 Register offsets, field positions, reset values and divider counts of the measurement timer.
 Assumes an 8-bit register port with a 5-bit word address.
*/
`ifndef MT_MAP_SVH
`define MT_MAP_SVH

`define MT_ADDR_W 5
`define MT_PIN_W 5

// Register offsets
`define MT_OFS_TMR_L 5'h00
`define MT_OFS_TMR_H 5'h01
`define MT_OFS_TMR_U 5'h02
`define MT_OFS_PRD_L 5'h03
`define MT_OFS_PRD_H 5'h04
`define MT_OFS_PRD_U 5'h05
`define MT_OFS_CPR_L 5'h06
`define MT_OFS_CPR_H 5'h07
`define MT_OFS_CPR_U 5'h08
`define MT_OFS_CPW_L 5'h09
`define MT_OFS_CPW_H 5'h0A
`define MT_OFS_CPW_U 5'h0B
`define MT_OFS_CON 5'h0C
`define MT_OFS_SEL 5'h0D
`define MT_OFS_STAT 5'h0E
`define MT_OFS_IRQ_STAT 5'h0F
`define MT_OFS_IRQ_MASK 5'h10

// Control fields
`define MT_CON_EN 0
`define MT_CON_W16 1
`define MT_CON_MODE_LO 2
`define MT_SEL_CLK_LO 0
`define MT_SEL_WIN_LO 2
`define MT_SEL_SIG 4

// Status fields
`define MT_STAT_PRUP 7
`define MT_STAT_PWUP 6
`define MT_STAT_TRST 5

// Interrupt fields
`define MT_IRQ_MATCH 0
`define MT_IRQ_ACQ 1

// Reset values
`define MT_PRD_RST 24'hFF_FFFF
`define MT_MASK24 24'hFF_FFFF
`define MT_MASK16 24'h00_FFFF

// Clock divider terminal counts
`define MT_DIV_A_MAX 2'h3
`define MT_DIV_B_MAX 4'hF

`endif

// ===== mt_pkg.sv
/*
 Types of the measurement timer: measurement modes and acquisition states.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package mt_pkg;
    typedef enum logic [1:0] {
        MT_MODE_TIMER,
        MT_MODE_PERIOD,
        MT_MODE_FLIGHT,
        MT_MODE_GATED
    } mt_mode_t;

    typedef enum logic {
        MT_IDLE,
        MT_ACQ
    } mt_state_t;
endpackage

// ===== mt_cnt_if.sv
/*
 Signals between the measurement timer control and its 24-bit counter.
 Assumes both ends run on the same clock.
*/
interface mt_cnt_if;
    logic tick;
    logic clr;
    logic wide16;
    logic [2:0] ld_en;
    logic [7:0] ld_data;
    logic [23:0] period;
    logic [23:0] count;
    logic match;

    modport ctl (output tick, clr, wide16, ld_en, ld_data, period, input count, match);
    modport cnt (input tick, clr, wide16, ld_en, ld_data, period, output count, match);
endinterface

// ===== mt_sync.sv
/*
 Two-flop synchronisers for the measured pins.
 Assumes the pins are asynchronous to clk.
*/
`include "mt_map.svh"

module mt_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pins in, synchronised levels out
    input wire logic [`MT_PIN_W-1:0] din,
    output logic [`MT_PIN_W-1:0] dout
);
    logic [`MT_PIN_W-1:0] meta;

    // One synchroniser per pin
    for (genvar g = 0; g < `MT_PIN_W; g++) begin : g_bit
        always_ff @(posedge clk) begin
            if (rst) begin
                meta[g] <= 1'b0;
                dout[g] <= 1'b0;
            end else begin
                meta[g] <= din[g];
                dout[g] <= meta[g];
            end
        end
    end
endmodule

// ===== mt_counter.sv
/*
 The 24-bit measurement counter with byte loads, 16-bit option and period match.
 Assumes the control end drives every interface input from the same clock.
*/
`include "mt_map.svh"

module mt_counter (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control end
    mt_cnt_if.cnt port
);
    logic [23:0] mask;
    logic hit;
    logic [23:0] ld_val;
    logic [23:0] inc;
    logic [23:0] next_count;
    logic next_match;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    assign mask = port.wide16 ? `MT_MASK16 : `MT_MASK24;
    assign hit = (port.count & mask) == (port.period & mask);
    assign inc = (port.count + 24'h00_0001) & mask;

    // Byte loads from software
    for (genvar g = 0; g < 3; g++) begin : g_ld
        assign ld_val[g*8 +: 8] = port.ld_en[g] ? port.ld_data : port.count[g*8 +: 8];
    end

    assign next_count = port.clr ? 24'h00_0000 :
                        (|port.ld_en) ? ld_val :
                        port.tick ? (hit ? 24'h00_0000 : inc) :
                        port.count;
    assign next_match = port.tick && hit && !port.clr && !(|port.ld_en);

    always_ff @(posedge clk) begin
        if (rst) begin
            port.count <= 24'h00_0000;
            port.match <= 1'b0;
        end else begin
            port.count <= next_count;
            port.match <= next_match;
        end
    end

    property p_wide16_upper;
        port.wide16 && !port.clr && port.ld_en == 3'h0 |=> $stable(port.count[23:16]);
    endproperty
    a_wide16_upper: assert property (p_wide16_upper) else $error("upper byte moved in 16-bit mode");

    property p_match_wrap;
        port.tick && hit && !port.clr && port.ld_en == 3'h0 |=> port.match && port.count == 24'h00_0000;
    endproperty
    a_match_wrap: assert property (p_match_wrap) else $error("period match did not wrap");
endmodule

// ===== mt_top.sv
/*
 Signal measurement timer: register port, source selection, acquisition control,
 capture registers and interrupt. Assumes a one-cycle register master on MCLK and
 asynchronous measured pins.
*/
// Design decisions made here: strobed register access and the register offsets.
// What this block does
// - 24-bit counter in three software read/write bytes low, high, upper.
// - Optional 16-bit counting width instead of 24 bits.
// - Two 24-bit capture registers, width and period, and a 24-bit period match.
// - Measures pulse width, period, duty cycle and edge-to-edge delay of two signals.
// - Interrupt event when the counter matches the period match value.
// - Interrupt event when an acquisition completes.
// - Software selects clock, window and signal sources.
// - Status shows counting, window open and acquisition in progress.
// - Period update request bit copies the buffer into period match, then clears itself.
// - Captured width readable as three read-only bytes; reset content undefined.
// - Exactly one measurement timer instance.
`include "mt_map.svh"

module mt_top (
    // Clock and reset
    input wire logic MCLK,
    input wire logic SYS_RST,
    // Register port
    input wire logic [`MT_ADDR_W-1:0] ADDR,
    input wire logic [7:0] WR_DATA,
    input wire logic WR_EN,
    input wire logic RD_EN,
    output logic [7:0] RD_DATA,
    // Measured pins
    input wire logic CLK_PIN,
    input wire logic [1:0] WIN_PIN,
    input wire logic [1:0] SIG_PIN,
    // Interrupt
    output logic IRQ
);
    logic [`MT_PIN_W-1:0] pin_s;
    logic [`MT_PIN_W-1:0] pin_d;
    logic con_en;
    logic con_w16;
    mt_pkg::mt_mode_t con_mode;
    logic [1:0] sel_clk;
    logic [1:0] sel_win;
    logic sel_sig;
    logic [23:0] prb;
    logic [23:0] prd;
    logic [23:0] cpr;
    logic [23:0] cpw;
    logic prup;
    logic pwup;
    logic trst;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [3:0] div;
    mt_pkg::mt_state_t state;
    mt_pkg::mt_state_t next_state;
    logic [7:0] next_rd;
    logic [1:0] next_irq_stat;
    logic [23:0] next_prb;

    mt_cnt_if cnt_if ();

    function automatic logic [7:0] byte_of(input logic [23:0] v, input logic [1:0] i);
        byte_of = (i == 2'd0) ? v[7:0] : (i == 2'd1) ? v[15:8] : v[23:16];
    endfunction

    function automatic logic win_pick(input logic [`MT_PIN_W-1:0] p, input logic [1:0] s);
        win_pick = (s == 2'd0) ? 1'b1 : (s == 2'd1) ? p[1] : (s == 2'd2) ? p[2] : p[4];
    endfunction

    // Pin synchronisers
    mt_sync u_sync (
        .clk(MCLK),
        .rst(SYS_RST),
        .din({SIG_PIN, WIN_PIN, CLK_PIN}),
        .dout(pin_s)
    );

    // The single counter
    mt_counter u_cnt (
        .clk(MCLK),
        .rst(SYS_RST),
        .port(cnt_if.cnt)
    );

    // Address decode
    wire wr_tmr_l = WR_EN && ADDR == `MT_OFS_TMR_L;
    wire wr_tmr_h = WR_EN && ADDR == `MT_OFS_TMR_H;
    wire wr_tmr_u = WR_EN && ADDR == `MT_OFS_TMR_U;
    wire wr_prd_l = WR_EN && ADDR == `MT_OFS_PRD_L;
    wire wr_prd_h = WR_EN && ADDR == `MT_OFS_PRD_H;
    wire wr_prd_u = WR_EN && ADDR == `MT_OFS_PRD_U;
    wire wr_con = WR_EN && ADDR == `MT_OFS_CON;
    wire wr_sel = WR_EN && ADDR == `MT_OFS_SEL;
    wire wr_stat = WR_EN && ADDR == `MT_OFS_STAT;
    wire wr_mask = WR_EN && ADDR == `MT_OFS_IRQ_MASK;
    wire rd_irq = RD_EN && ADDR == `MT_OFS_IRQ_STAT;

    // Source selection
    wire div_a = div[1:0] == `MT_DIV_A_MAX;
    wire div_b = div == `MT_DIV_B_MAX;
    wire clk_rise = pin_s[0] && !pin_d[0];
    wire clk_tick = (sel_clk == 2'd0) ? 1'b1 : (sel_clk == 2'd1) ? div_a : (sel_clk == 2'd2) ? div_b : clk_rise;
    wire win_lvl = win_pick(pin_s, sel_win);
    wire win_prev = win_pick(pin_d, sel_win);
    wire sig_lvl = sel_sig ? pin_s[4] : pin_s[3];
    wire sig_prev = sel_sig ? pin_d[4] : pin_d[3];
    wire win_rise = win_lvl && !win_prev;
    wire sig_rise = sig_lvl && !sig_prev;
    wire sig_fall = !sig_lvl && sig_prev;

    // Mode events
    wire is_tmr = con_mode == mt_pkg::MT_MODE_TIMER;
    wire is_per = con_mode == mt_pkg::MT_MODE_PERIOD;
    wire is_flt = con_mode == mt_pkg::MT_MODE_FLIGHT;
    wire is_gat = con_mode == mt_pkg::MT_MODE_GATED;
    wire acq = state == mt_pkg::MT_ACQ;
    wire start_ev = con_en && (((is_per || is_gat) && sig_rise) || (is_flt && win_rise));
    wire cap_w = con_en && acq && (((is_per || is_gat) && sig_fall) || (is_flt && sig_rise));
    wire cap_p = con_en && acq && (is_per || is_flt) && sig_rise;
    wire done_ev = con_en && acq && (((is_per || is_flt) && sig_rise) || (is_gat && sig_fall));
    wire running = con_en && (is_tmr ? win_lvl : acq);

    // Counter control
    assign cnt_if.tick = running && clk_tick;
    assign cnt_if.clr = trst || start_ev;
    assign cnt_if.wide16 = con_w16;
    assign cnt_if.ld_en = {wr_tmr_u, wr_tmr_h, wr_tmr_l};
    assign cnt_if.ld_data = WR_DATA;
    assign cnt_if.period = prd;

    // Acquisition sequencing
    assign next_state = (!con_en || is_tmr) ? mt_pkg::MT_IDLE :
                        start_ev ? mt_pkg::MT_ACQ :
                        done_ev ? mt_pkg::MT_IDLE :
                        state;

    // Period buffer byte writes
    assign next_prb = {wr_prd_u ? WR_DATA : prb[23:16],
                       wr_prd_h ? WR_DATA : prb[15:8],
                       wr_prd_l ? WR_DATA : prb[7:0]};

    // New events win over the read clear
    assign next_irq_stat = {done_ev, cnt_if.match} | (rd_irq ? 2'b00 : irq_stat);

    always_comb begin
        unique case (ADDR)
            `MT_OFS_TMR_L: next_rd = byte_of(cnt_if.count, 2'd0);
            `MT_OFS_TMR_H: next_rd = byte_of(cnt_if.count, 2'd1);
            `MT_OFS_TMR_U: next_rd = byte_of(cnt_if.count, 2'd2);
            `MT_OFS_PRD_L: next_rd = byte_of(prb, 2'd0);
            `MT_OFS_PRD_H: next_rd = byte_of(prb, 2'd1);
            `MT_OFS_PRD_U: next_rd = byte_of(prb, 2'd2);
            `MT_OFS_CPR_L: next_rd = byte_of(cpr, 2'd0);
            `MT_OFS_CPR_H: next_rd = byte_of(cpr, 2'd1);
            `MT_OFS_CPR_U: next_rd = byte_of(cpr, 2'd2);
            `MT_OFS_CPW_L: next_rd = byte_of(cpw, 2'd0);
            `MT_OFS_CPW_H: next_rd = byte_of(cpw, 2'd1);
            `MT_OFS_CPW_U: next_rd = byte_of(cpw, 2'd2);
            `MT_OFS_CON: next_rd = {4'h0, con_mode, con_w16, con_en};
            `MT_OFS_SEL: next_rd = {3'h0, sel_sig, sel_win, sel_clk};
            `MT_OFS_STAT: next_rd = {prup, pwup, trst, 2'b00, running, win_lvl, acq};
            `MT_OFS_IRQ_STAT: next_rd = {6'h00, irq_stat};
            `MT_OFS_IRQ_MASK: next_rd = {6'h00, irq_mask};
            default: next_rd = 8'h00;
        endcase
    end

    // Pin history and divider
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            pin_d <= '0;
            div <= 4'h0;
        end else begin
            pin_d <= pin_s;
            div <= div + 4'h1;
        end
    end

    // Configuration
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            con_en <= 1'b0;
            con_w16 <= 1'b0;
            con_mode <= mt_pkg::MT_MODE_TIMER;
            sel_clk <= 2'd0;
            sel_win <= 2'd0;
            sel_sig <= 1'b0;
            irq_mask <= 2'b00;
        end else begin
            if (wr_con) begin
                con_en <= WR_DATA[`MT_CON_EN];
                con_w16 <= WR_DATA[`MT_CON_W16];
                con_mode <= mt_pkg::mt_mode_t'(WR_DATA[`MT_CON_MODE_LO +: 2]);
            end
            if (wr_sel) begin
                sel_clk <= WR_DATA[`MT_SEL_CLK_LO +: 2];
                sel_win <= WR_DATA[`MT_SEL_WIN_LO +: 2];
                sel_sig <= WR_DATA[`MT_SEL_SIG];
            end
            if (wr_mask) begin
                irq_mask <= WR_DATA[1:0];
            end
        end
    end

    // Update requests hold one cycle, then hardware clears them
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            prup <= 1'b0;
            pwup <= 1'b0;
            trst <= 1'b0;
        end else begin
            prup <= wr_stat && WR_DATA[`MT_STAT_PRUP];
            pwup <= wr_stat && WR_DATA[`MT_STAT_PWUP];
            trst <= wr_stat && WR_DATA[`MT_STAT_TRST];
        end
    end

    // Period buffer and active period match
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            prb <= `MT_PRD_RST;
            prd <= `MT_PRD_RST;
        end else begin
            prb <= next_prb;
            if (prup) begin
                prd <= prb;
            end
        end
    end

    // Capture registers keep no reset value
    always_ff @(posedge MCLK) begin
        if (cap_w || pwup) begin
            cpw <= cnt_if.count;
        end
        if (cap_p) begin
            cpr <= cnt_if.count;
        end
    end

    // State, interrupt and read data
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            state <= mt_pkg::MT_IDLE;
            irq_stat <= 2'b00;
            IRQ <= 1'b0;
            RD_DATA <= 8'h00;
        end else begin
            state <= next_state;
            irq_stat <= next_irq_stat;
            IRQ <= |(irq_stat & irq_mask);
            RD_DATA <= RD_EN ? next_rd : 8'h00;
        end
    end

    default clocking @(posedge MCLK); endclocking
    default disable iff (SYS_RST);

    property p_tmr_load;
        wr_tmr_l && !cnt_if.clr |=> cnt_if.count[7:0] == $past(WR_DATA);
    endproperty
    a_tmr_load: assert property (p_tmr_load) else $error("timer low byte write lost");

    property p_prd_update;
        wr_stat && WR_DATA[`MT_STAT_PRUP] ##1 !(wr_stat && WR_DATA[`MT_STAT_PRUP]) |=> !prup && prd == $past(prb);
    endproperty
    a_prd_update: assert property (p_prd_update) else $error("period update failed");

    property p_width_update;
        pwup |=> cpw == $past(cnt_if.count);
    endproperty
    a_width_update: assert property (p_width_update) else $error("width update failed");

    property p_gated_cap;
        is_gat && con_en && acq && sig_fall && !start_ev |=> cpw == $past(cnt_if.count) && !acq;
    endproperty
    a_gated_cap: assert property (p_gated_cap) else $error("gated width not captured");

    property p_acq_irq;
        done_ev |=> irq_stat[`MT_IRQ_ACQ] ##1 IRQ == irq_mask[`MT_IRQ_ACQ] || $past(irq_stat[0] && irq_mask[0]);
    endproperty
    a_acq_irq: assert property (p_acq_irq) else $error("acquisition interrupt missing");

    property p_match_irq;
        cnt_if.match |=> irq_stat[`MT_IRQ_MATCH];
    endproperty
    a_match_irq: assert property (p_match_irq) else $error("match interrupt flag missing");

    property p_div_tick;
        sel_clk == 2'd2 && $stable(sel_clk) |-> ##[0:15] clk_tick;
    endproperty
    a_div_tick: assert property (p_div_tick) else $error("divided clock tick missing");

    property p_stat_read;
        RD_EN && ADDR == `MT_OFS_STAT |=> RD_DATA[2:0] == $past({running, win_lvl, acq});
    endproperty
    a_stat_read: assert property (p_stat_read) else $error("status flags read wrong");

    property p_cpw_ro;
        WR_EN && ADDR == `MT_OFS_CPW_L && !cap_w && !pwup |=> $stable(cpw);
    endproperty
    a_cpw_ro: assert property (p_cpw_ro) else $error("captured width changed by write");
endmodule

// ===== mt_pins_model.sv
/*
 Model of the signals that the measurement timer watches: count clock, windows, signals.
 Assumes the bench commands it through its tasks, on the same clock as the block.
*/
module mt_pins_model (
    // Clock
    input wire logic clk,
    // Measured pins
    output logic clk_pin,
    output logic [1:0] win_pin,
    output logic [1:0] sig_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] div = 2'h0;

    initial begin
        clk_pin = 1'b0;
        win_pin = 2'h0;
        sig_pin = 2'h0;
    end

    // External count clock, free running
    always @(posedge clk) begin
        div <= div + 2'h1;
        clk_pin <= div[1];
    end

    // High pulse of n cycles; an n of 0 or less drives no pulse at all
    task automatic pulse(input int idx, input int n);
        @(posedge clk);
        sig_pin[idx] <= 1'b1;
        repeat (n) @(posedge clk);
        sig_pin[idx] <= 1'b0;
    endtask

    task automatic set_win(input int idx, input logic v);
        @(posedge clk);
        win_pin[idx] <= v;
    endtask
endmodule

// ===== mt_top_test.sv
/*
 Self-checking bench of the measurement timer: register port driver, read monitor, pin model.
 Assumes the register map and field positions of the block's map header.
*/
`include "mt_map.svh"

module mt_top_test;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [7:0] d;
        logic [7:0] m;
    } mt_exp_t;

    logic mclk = 1'b0;
    logic sys_rst;
    logic [`MT_ADDR_W-1:0] addr;
    logic [7:0] wr_data;
    logic wr_en;
    logic rd_en;
    logic [7:0] rd_data;
    logic clk_pin;
    logic [1:0] win_pin;
    logic [1:0] sig_pin;
    logic irq;
    logic rd_pend;
    logic [23:0] last24;
    logic [23:0] tm;
    logic [23:0] w [2];
    logic [31:0] seed;
    int n [2];
    int i;
    int n_errors;
    int checks_done;
    mt_exp_t exq [$];

    always #2 mclk = ~mclk;

    mt_pins_model pins (
        .clk(mclk),
        .clk_pin(clk_pin),
        .win_pin(win_pin),
        .sig_pin(sig_pin)
    );

    mt_top u_dut (
        .MCLK(mclk),
        .SYS_RST(sys_rst),
        .ADDR(addr),
        .WR_DATA(wr_data),
        .WR_EN(wr_en),
        .RD_EN(rd_en),
        .RD_DATA(rd_data),
        .CLK_PIN(clk_pin),
        .WIN_PIN(win_pin),
        .SIG_PIN(sig_pin),
        .IRQ(irq)
    );

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic close_out();
        if (n_errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic cmp_val(input logic [23:0] got, input logic [23:0] exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t %s: got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic cmp_rd(input mt_exp_t e);
        checks_done++;
        if ((rd_data & e.m) !== (e.d & e.m)) begin
            n_errors++;
            $display("CHECK FAILED %0t read data %h expected %h mask %h", $time, rd_data, e.d, e.m);
        end
    endtask

    // One strobe cycle; a read notes its expectation
    task automatic op(input logic wr, input logic [`MT_ADDR_W-1:0] a, input logic [7:0] d, input logic [7:0] m);
        @(posedge mclk);
        addr <= a;
        wr_data <= wr ? d : 8'(rnd());
        wr_en <= wr;
        rd_en <= !wr;
        if (!wr) exq.push_back({d, m});
    endtask

    task automatic idle();
        @(posedge mclk);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
    endtask

    task automatic wr(input logic [`MT_ADDR_W-1:0] a, input logic [7:0] d);
        op(1'b1, a, d, 8'h00);
        idle();
    endtask

    task automatic rd(input logic [`MT_ADDR_W-1:0] a, input logic [7:0] e, input logic [7:0] m);
        op(1'b0, a, e, m);
        idle();
    endtask

    task automatic get24(input logic [`MT_ADDR_W-1:0] a);
        rd(a, 8'h00, 8'h00);
        rd(5'(a + 5'h01), 8'h00, 8'h00);
        rd(5'(a + 5'h02), 8'h00, 8'h00);
        @(negedge mclk);
        @(posedge mclk);
    endtask

    task automatic wait_irq(input int lim);
        int k;
        k = 0;
        while (irq !== 1'b1 && k < lim) begin
            @(posedge mclk);
            k++;
        end
    endtask

    // Read monitor: data stand in the cycle after the strobe
    always @(posedge mclk) rd_pend <= rd_en;
    always @(negedge mclk) begin
        if (rd_pend) begin
            last24 <= {rd_data, last24[23:8]};
            if (exq.size() > 0) cmp_rd(exq.pop_front());
        end
    end

    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        close_out();
    end

    initial begin
        sys_rst = 1'b1;
        addr = '0;
        wr_data = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        rd_pend = 1'b0;
        last24 = 24'h00_0000;
        n_errors = 0;
        checks_done = 0;
        seed = 32'hd2ec_2e77;
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        // Reset values, unmapped address
        rd(`MT_OFS_STAT, 8'h00, 8'hE0);
        for (i = 0; i < 3; i++) rd(5'(`MT_OFS_PRD_L + i), 8'hFF, 8'hFF);
        rd(`MT_OFS_IRQ_STAT, 8'h00, 8'hFF);
        rd(`MT_OFS_IRQ_MASK, 8'h00, 8'hFF);
        rd(5'h1F, 8'h00, 8'hFF);
        // Counter bytes read and write
        tm = 24'(rnd());
        for (i = 0; i < 3; i++) wr(5'(`MT_OFS_TMR_L + i), tm[i*8 +: 8]);
        for (i = 0; i < 3; i++) rd(5'(`MT_OFS_TMR_L + i), tm[i*8 +: 8], 8'hFF);
        // Width update request, read-only capture
        op(1'b1, `MT_OFS_STAT, 8'h40, 8'h00);
        op(1'b0, `MT_OFS_STAT, 8'h40, 8'h40);
        rd(`MT_OFS_STAT, 8'h00, 8'hE0);
        wr(`MT_OFS_CPW_L, ~tm[7:0]);
        for (i = 0; i < 3; i++) rd(5'(`MT_OFS_CPW_L + i), tm[i*8 +: 8], 8'hFF);
        // Period match only after the period update request
        wr(`MT_OFS_PRD_L, 8'h05);
        wr(`MT_OFS_PRD_H, 8'h00);
        wr(`MT_OFS_PRD_U, 8'h00);
        wr(`MT_OFS_STAT, 8'h20);
        wr(`MT_OFS_IRQ_MASK, 8'h01);
        wr(`MT_OFS_CON, 8'h01);
        repeat (30) @(posedge mclk);
        cmp_val({23'h0, irq}, 24'h0, "match before update");
        op(1'b1, `MT_OFS_STAT, 8'h80, 8'h00);
        op(1'b0, `MT_OFS_STAT, 8'h80, 8'h80);
        op(1'b1, `MT_OFS_STAT, 8'h20, 8'h00);
        rd(`MT_OFS_STAT, 8'h00, 8'hC0);
        wait_irq(40);
        cmp_val({23'h0, irq}, 24'h1, "match irq");
        wr(`MT_OFS_CON, 8'h00);
        rd(`MT_OFS_IRQ_STAT, 8'h01, 8'h01);
        rd(`MT_OFS_IRQ_STAT, 8'h00, 8'h01);
        repeat (3) @(posedge mclk);
        cmp_val({23'h0, irq}, 24'h0, "irq after clear");
        // 16-bit width masks the period match value
        wr(`MT_OFS_PRD_U, 8'h01);
        wr(`MT_OFS_STAT, 8'h80);
        for (i = 0; i < 2; i++) begin
            wr(`MT_OFS_CON, 8'h00);
            rd(`MT_OFS_IRQ_STAT, 8'h00, 8'h00);
            wr(`MT_OFS_STAT, 8'h20);
            wr(`MT_OFS_CON, i ? 8'h03 : 8'h01);
            repeat (30) @(posedge mclk);
            wr(`MT_OFS_CON, 8'h00);
            rd(`MT_OFS_IRQ_STAT, 8'(i), 8'h01);
        end
        // Gated width capture and acquisition interrupt
        wr(`MT_OFS_PRD_U, 8'hFF);
        wr(`MT_OFS_PRD_H, 8'hFF);
        wr(`MT_OFS_PRD_L, 8'hFF);
        wr(`MT_OFS_STAT, 8'h80);
        wr(`MT_OFS_IRQ_MASK, 8'h02);
        wr(`MT_OFS_SEL, 8'h00);
        wr(`MT_OFS_CON, 8'h0D);
        for (i = 0; i < 2; i++) begin
            n[i] = 4 + int'(rnd() % 20);
            pins.pulse(0, n[i]);
            wait_irq(40);
            cmp_val({23'h0, irq}, 24'h1, "acquisition irq");
            rd(`MT_OFS_IRQ_STAT, 8'h02, 8'h02);
            get24(`MT_OFS_CPW_L);
            w[i] = last24;
        end
        cmp_val(w[1] - w[0], 24'(n[1] - n[0]), "width difference");
        // Period mode on the second signal pin: period minus width is the low time
        wr(`MT_OFS_CON, 8'h00);
        wr(`MT_OFS_SEL, 8'h10);
        wr(`MT_OFS_CON, 8'h05);
        n[0] = 4 + int'(rnd() % 20);
        n[1] = 2 + int'(rnd() % 10);
        pins.pulse(1, n[0]);
        repeat (n[1]) @(posedge mclk);
        pins.pulse(1, n[0]);
        repeat (6) @(posedge mclk);
        cmp_val({23'h0, irq}, 24'h1, "period irq");
        wr(`MT_OFS_CON, 8'h00);
        rd(`MT_OFS_IRQ_STAT, 8'h02, 8'h02);
        get24(`MT_OFS_CPR_L);
        tm = last24;
        get24(`MT_OFS_CPW_L);
        cmp_val(tm - last24, 24'(n[1] + 1), "period minus width");
        // Count clock sources over 64 enabled cycles: /4, /16, count clock pin
        for (i = 1; i < 4; i++) begin
            wr(`MT_OFS_CON, 8'h00);
            wr(`MT_OFS_SEL, 8'(i));
            wr(`MT_OFS_STAT, 8'h20);
            wr(`MT_OFS_CON, 8'h01);
            repeat (62) @(posedge mclk);
            wr(`MT_OFS_CON, 8'h00);
            rd(`MT_OFS_TMR_L, (i == 2) ? 8'h04 : 8'h10, 8'hFF);
        end
        // Window source selection and live status
        wr(`MT_OFS_CON, 8'h00);
        wr(`MT_OFS_SEL, 8'h04);
        wr(`MT_OFS_STAT, 8'h20);
        wr(`MT_OFS_CON, 8'h01);
        repeat (5) @(posedge mclk);
        rd(`MT_OFS_TMR_L, 8'h00, 8'hFF);
        rd(`MT_OFS_STAT, 8'h00, 8'h06);
        pins.set_win(0, 1'b1);
        repeat (6) @(posedge mclk);
        rd(`MT_OFS_STAT, 8'h06, 8'h06);
        repeat (4) @(posedge mclk);
        close_out();
    end
endmodule
